// File: gafs_board.sv
`timescale 1ns/1ns
// board side: a pin reads back its own drive, otherwise the external level
module gafs_board (
   input wire logic [4:0] pinOut,
   input wire logic [4:0] pinOe,
   input wire logic [4:0] extLevel,
   output logic [4:0] pinIn
);
   // per-pin wire resolution, no pin is left floating
   assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

// File: gafs_pin_role.sv
`timescale 1ns/1ns
// one pin: routes internal outputs or fans the pin input out by selector
module gafs_pin_role (
   input wire logic [3:0] sel,
   input wire logic pinIn,
   input wire logic gpioOut,
   input wire logic gpioOe,
   input wire logic [3:0] altOut,
   input wire logic [3:0] altIsOut,
   output logic pinOut,
   output logic pinOe,
   output logic [3:0] roleIn
);
   wire logic altSel;
   wire logic [1:0] idx;
   // codes 1..4 select a role; others stay general purpose
   assign altSel = (sel >= gafs_pkg::FN_1) && (sel <= gafs_pkg::FN_4);
   assign idx = 2'(sel - gafs_pkg::FN_1);
   assign pinOut = (altSel && altIsOut[idx]) ? altOut[idx] : gpioOut;
   assign pinOe = altSel ? altIsOut[idx] : gpioOe;
   always_comb begin
      roleIn = 4'h0;
      if (altSel && !altIsOut[idx]) begin
         roleIn[idx] = pinIn;
      end
   end
endmodule

// File: gafs_pkg.sv
package gafs_pkg;
   localparam logic [7:0] ADDR_SEL_C = 8'h8e;
   localparam logic [7:0] ADDR_SEL_D = 8'h8f;
   localparam int SEL_W = 4;
   localparam int P8_LSB = 0;
   localparam int P9_LSB = 4;
   localparam int P10_LSB = 8;
   localparam int P11_LSB = 12;
   localparam int P12_LSB = 0;
   localparam logic [3:0] FN_GPIO = 4'h0;
   localparam logic [3:0] FN_1 = 4'h1;
   localparam logic [3:0] FN_2 = 4'h2;
   localparam logic [3:0] FN_3 = 4'h3;
   localparam logic [3:0] FN_4 = 4'h4;
   // mask defaults, values arbitrary per variant
   localparam logic [15:0] DEF_SEL_C = 16'h0000;
   localparam logic [15:0] DEF_SEL_D = 16'h0000;
endpackage

// File: gafs_tb_top.sv
`timescale 1ns/1ns
module gafs_tb_top;
   logic clk = 1'b0, rst = 1'b1, smReset = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic [15:0] rdata;
   logic [4:0] pinIn, pinOut, pinOe, ext = 5'h00, gpioOut = 5'h00, gpioOe = 5'h00;
   logic [11:0] src = 12'h000;
   logic [8:0] ins;
   int n_errors = 0;
   int num_checks = 0;
   // output roles: pin, code, source index
   logic [11:0] outTab [18] = '{12'h017, 12'h02b, 12'h038, 12'h04a, 12'h117, 12'h123, 12'h138, 12'h149, 12'h210,
      12'h223, 12'h234, 12'h311, 12'h323, 12'h334, 12'h412, 12'h423, 12'h435, 12'h446};
   // input roles: pin, code, role output index
   logic [11:0] inTab [11] = '{12'h016, 12'h027, 12'h031, 12'h045, 12'h112, 12'h123, 12'h131, 12'h144, 12'h418,
      12'h320, 12'h231};
   always #5 clk = ~clk;
   gafs_board u_gafs_board (.pinOut(pinOut), .pinOe(pinOe), .extLevel(ext), .pinIn(pinIn));
   gafs_top u_gafs_top (.clk(clk), .rst(rst), .smReset(smReset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .gpioOut(gpioOut), .gpioOe(gpioOe),
      .currentSinkCCtrl(src[0]), .currentSinkDCtrl(src[1]), .currentSinkECtrl(src[2]),
      .lineAboveBatteryFlag(src[3]), .chargeIndicator(src[4]), .lineSwitchState(src[5]), .clk32k(src[6]),
      .supplyFaultN(src[7]), .batteryFaultN(src[8]), .memoryResetN(src[9]), .systemResetN(src[10]),
      .adcBitClockOut(src[11]), .wakeRequestN(ins[0]), .powerOffRequest(ins[1]), .hostAlivePulse(ins[2]),
      .seqMask(ins[3]), .hibernateLevel(ins[4]), .hibernateEdge(ins[5]), .manualResetN(ins[6]),
      .adcBitClockIn(ins[7]), .chipReset(ins[8]));
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wrReg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rdReg(input logic [7:0] a, input logic [15:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("rdata", rdata, exp);
   endtask
   // write then read back with no gap between the strobes
   task automatic wrRd(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("rdata", rdata, d);
   endtask
   // one pin gets the code, every other selector goes back to plain pin
   task automatic setSel(input int p, input logic [3:0] c);
      wrReg(gafs_pkg::ADDR_SEL_C, (p == 4) ? 16'h0000 : 16'(c) << (4 * p));
      wrReg(gafs_pkg::ADDR_SEL_D, (p == 4) ? {12'h000, c} : 16'h0000);
      @(posedge clk);
      #1;
   endtask
   task automatic stop_test();
      if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      #50000;
      n_errors++;
      stop_test();
   end
   initial begin
      int p, c, k;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdReg(gafs_pkg::ADDR_SEL_C, gafs_pkg::DEF_SEL_C);
      rdReg(gafs_pkg::ADDR_SEL_D, gafs_pkg::DEF_SEL_D);
      wrRd(gafs_pkg::ADDR_SEL_C, 16'h1234);
      wrReg(gafs_pkg::ADDR_SEL_D, 16'hfff4);
      rdReg(gafs_pkg::ADDR_SEL_D, 16'h0004);
      rdReg(8'h90, 16'h0000);
      smReset <= 1'b1;
      wr <= 1'b1;
      addr <= gafs_pkg::ADDR_SEL_C;
      wdata <= 16'h5555;
      @(posedge clk);
      smReset <= 1'b0;
      wr <= 1'b0;
      rdReg(gafs_pkg::ADDR_SEL_C, gafs_pkg::DEF_SEL_C);
      rdReg(gafs_pkg::ADDR_SEL_D, gafs_pkg::DEF_SEL_D);
      // output roles: a one-hot source must reach the pin, its inverse must not
      gpioOe <= 5'h1f;
      foreach (outTab[i]) for (int v = 0; v < 2; v++) begin
         p = outTab[i][11:8];
         c = outTab[i][7:4];
         k = outTab[i][3:0];
         src <= v ? ~(12'h001 << k) : 12'h001 << k;
         setSel(p, c[3:0]);
         chk("pinOut", 16'(pinOut[p]), 16'(v == 0));
         chk("pinOe", 16'(pinOe[p]), 16'h0001);
      end
      // input roles: pin level and all sources agree, role output follows
      gpioOe <= 5'h00;
      foreach (inTab[i]) for (int v = 0; v < 2; v++) begin
         p = inTab[i][11:8];
         c = inTab[i][7:4];
         k = inTab[i][3:0];
         ext <= {5{v[0]}};
         src <= {12{v[0]}};
         setSel(p, c[3:0]);
         chk("roleIn", 16'(ins[k]), 16'(v));
      end
      // plain and unassigned codes keep the pin general purpose, roles idle
      gpioOe <= 5'h1f;
      for (p = 0; p < 5; p++) for (c = 0; c < 16; c++) if (c == 0 || c > 4) begin
         gpioOut <= {5{c[0]}};
         src <= {12{~c[0]}};
         setSel(p, c[3:0]);
         chk("gpio", {pinOut[p], pinOe[p], ins}, {c[0], 1'b1, 9'h041});
      end
      stop_test();
   end
endmodule

// File: gafs_top.sv
`timescale 1ns/1ns
// function select for pins 8..12
module gafs_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic smReset,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic [4:0] pinIn,
   output logic [4:0] pinOut,
   output logic [4:0] pinOe,
   input wire logic [4:0] gpioOut,
   input wire logic [4:0] gpioOe,
   input wire logic currentSinkCCtrl,
   input wire logic currentSinkDCtrl,
   input wire logic currentSinkECtrl,
   input wire logic lineAboveBatteryFlag,
   input wire logic chargeIndicator,
   input wire logic lineSwitchState,
   input wire logic clk32k,
   input wire logic supplyFaultN,
   input wire logic batteryFaultN,
   input wire logic memoryResetN,
   input wire logic systemResetN,
   input wire logic adcBitClockOut,
   output logic wakeRequestN,
   output logic powerOffRequest,
   output logic hostAlivePulse,
   output logic seqMask,
   output logic hibernateLevel,
   output logic hibernateEdge,
   output logic manualResetN,
   output logic adcBitClockIn,
   output logic chipReset
);
   logic [15:0] selC_q;
   logic [15:0] selD_q;
   logic [15:0] rdata_q;
   wire logic [3:0] pin8Sel;
   wire logic [3:0] pin9Sel;
   wire logic [3:0] pin10Sel;
   wire logic [3:0] pin11Sel;
   wire logic [3:0] pin12Sel;
   wire logic [3:0] in8;
   wire logic [3:0] in9;
   wire logic [3:0] in12;
   wire logic hitC;
   wire logic hitD;
   wire logic [15:0] rdMux;

   // register decode
   assign hitC = addr == gafs_pkg::ADDR_SEL_C;
   assign hitD = addr == gafs_pkg::ADDR_SEL_D;
   assign rdMux = hitC ? selC_q : (hitD ? selD_q : 16'h0000);
   assign pin8Sel = selC_q[gafs_pkg::P8_LSB +: gafs_pkg::SEL_W];
   assign pin9Sel = selC_q[gafs_pkg::P9_LSB +: gafs_pkg::SEL_W];
   assign pin10Sel = selC_q[gafs_pkg::P10_LSB +: gafs_pkg::SEL_W];
   assign pin11Sel = selC_q[gafs_pkg::P11_LSB +: gafs_pkg::SEL_W];
   assign pin12Sel = selD_q[gafs_pkg::P12_LSB +: gafs_pkg::SEL_W];

   // selectors; power state machine reset restores mask defaults
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         selC_q <= gafs_pkg::DEF_SEL_C;
         selD_q <= gafs_pkg::DEF_SEL_D;
      end else if (smReset) begin
         selC_q <= gafs_pkg::DEF_SEL_C;
         selD_q <= gafs_pkg::DEF_SEL_D;
      end else if (wr) begin
         if (hitC) begin
            selC_q <= wdata;
         end
         if (hitD) begin
            selD_q <= {12'h000, wdata[3:0]};
         end
      end
   end

   // read data one cycle after strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= rd ? rdMux : 16'h0000;
      end
   end
   assign rdata = rdata_q;

   // pin 8: mr_n, bit clock, power-off, edge hibernate / faults, bit clock, system reset
   gafs_pin_role u8 (
      .sel(pin8Sel),
      .pinIn(pinIn[0]),
      .gpioOut(gpioOut[0]),
      .gpioOe(gpioOe[0]),
      .altOut({systemResetN, batteryFaultN, adcBitClockOut, supplyFaultN}),
      .altIsOut(4'h0),
      .pinOut(),
      .pinOe(),
      .roleIn(in8)
   );
   // pin 8 as output uses same codes; a second instance decides output routing
   wire logic p8o;
   wire logic p8e;
   gafs_pin_role u8o (
      .sel(pin8Sel),
      .pinIn(1'b0),
      .gpioOut(gpioOut[0]),
      .gpioOe(gpioOe[0]),
      .altOut({systemResetN, batteryFaultN, adcBitClockOut, supplyFaultN}),
      .altIsOut(4'hf),
      .pinOut(p8o),
      .pinOe(p8e),
      .roleIn()
   );
   // pin 9
   wire logic p9o;
   wire logic p9e;
   gafs_pin_role u9 (
      .sel(pin9Sel),
      .pinIn(pinIn[1]),
      .gpioOut(gpioOut[1]),
      .gpioOe(gpioOe[1]),
      .altOut({memoryResetN, batteryFaultN, lineAboveBatteryFlag, supplyFaultN}),
      .altIsOut(4'hf),
      .pinOut(p9o),
      .pinOe(p9e),
      .roleIn()
   );
   gafs_pin_role u9i (
      .sel(pin9Sel),
      .pinIn(pinIn[1]),
      .gpioOut(1'b0),
      .gpioOe(1'b0),
      .altOut(4'h0),
      .altIsOut(4'h0),
      .pinOut(),
      .pinOe(),
      .roleIn(in9)
   );
   // pins 10 and 11 drive on codes 1..3; their input roles read the pin level itself
   wire logic p10o;
   wire logic p10e;
   wire logic p11o;
   wire logic p11e;
   gafs_pin_role u10 (
      .sel(pin10Sel),
      .pinIn(pinIn[2]),
      .gpioOut(gpioOut[2]),
      .gpioOe(gpioOe[2]),
      .altOut({1'b0, chargeIndicator, lineAboveBatteryFlag, currentSinkCCtrl}),
      .altIsOut(4'h7),
      .pinOut(p10o),
      .pinOe(p10e),
      .roleIn()
   );
   gafs_pin_role u11 (
      .sel(pin11Sel),
      .pinIn(pinIn[3]),
      .gpioOut(gpioOut[3]),
      .gpioOe(gpioOe[3]),
      .altOut({1'b0, chargeIndicator, lineAboveBatteryFlag, currentSinkDCtrl}),
      .altIsOut(4'h7),
      .pinOut(p11o),
      .pinOe(p11e),
      .roleIn()
   );
   // pin 12
   wire logic p12o;
   wire logic p12e;
   gafs_pin_role u12 (
      .sel(pin12Sel),
      .pinIn(pinIn[4]),
      .gpioOut(gpioOut[4]),
      .gpioOe(gpioOe[4]),
      .altOut({clk32k, lineSwitchState, lineAboveBatteryFlag, currentSinkECtrl}),
      .altIsOut(4'hf),
      .pinOut(p12o),
      .pinOe(p12e),
      .roleIn()
   );
   gafs_pin_role u12i (
      .sel(pin12Sel),
      .pinIn(pinIn[4]),
      .gpioOut(1'b0),
      .gpioOe(1'b0),
      .altOut(4'h0),
      .altIsOut(4'h0),
      .pinOut(),
      .pinOe(),
      .roleIn(in12)
   );

   // pin drive: pins 8, 9, 12 share codes between directions; gpio direction decides
   wire logic p8Alt;
   wire logic p9Alt;
   wire logic p12Alt;
   assign p8Alt = gpioOe[0];
   assign p9Alt = gpioOe[1];
   assign p12Alt = gpioOe[4];
   assign pinOut = {p12o, p11o, p10o, p9o, p8o};
   assign pinOe = {p12Alt ? p12e : 1'b0, p11e, p10e, p9Alt ? p9e : 1'b0, p8Alt ? p8e : 1'b0};

   // internal inputs of pins 8, 9, 12, gated so a pin driven as output does not feed a role; pins 10 and 11 feed theirs ungated
   wire logic in8En;
   wire logic in9En;
   wire logic in12En;
   assign in8En = !gpioOe[0];
   assign in9En = !gpioOe[1];
   assign in12En = !gpioOe[4];
   assign manualResetN = !(in8En && pin8Sel == gafs_pkg::FN_1 && !in8[0]);
   assign adcBitClockIn = in8En && in8[1];
   assign hibernateEdge = in8En && in8[3];
   assign hostAlivePulse = in9En && in9[0];
   assign seqMask = in9En && in9[1];
   assign hibernateLevel = in9En && in9[3];
   assign powerOffRequest = (in8En && in8[2]) || (in9En && in9[2]) || (pin10Sel == gafs_pkg::FN_3 && pinIn[2]);
   assign wakeRequestN = !(pin11Sel == gafs_pkg::FN_2 && !pinIn[3]);
   assign chipReset = in12En && in12[0];

   // checks
   selRestore_a: assert property (@(posedge clk) disable iff (rst)
      smReset |=> (selC_q == gafs_pkg::DEF_SEL_C && selD_q == gafs_pkg::DEF_SEL_D))
      else $error("selectors not restored");
   readBack_a: assert property (@(posedge clk) disable iff (rst)
      (wr && hitC && !smReset) ##1 (rd && hitC && !wr) |=> rdata == $past(selC_q))
      else $error("select c readback wrong");
   pin12Sink_a: assert property (@(posedge clk) disable iff (rst)
      (pin12Sel == gafs_pkg::FN_1 && gpioOe[4]) |-> (pinOe[4] && pinOut[4] == currentSinkECtrl))
      else $error("pin12 sink not routed");
   pin11Wake_a: assert property (@(posedge clk) disable iff (rst)
      pin11Sel == gafs_pkg::FN_2 |-> (wakeRequestN == pinIn[3] && pinOe[3]))
      else $error("wake not routed");
   pin10Sink_a: assert property (@(posedge clk) disable iff (rst)
      pin10Sel == gafs_pkg::FN_1 |-> (pinOe[2] && pinOut[2] == currentSinkCCtrl))
      else $error("sink c not routed");
   pin9Hib_a: assert property (@(posedge clk) disable iff (rst)
      (pin9Sel == gafs_pkg::FN_4 && !gpioOe[1]) |-> hibernateLevel == pinIn[1])
      else $error("hibernate level wrong");
   pin9Mem_a: assert property (@(posedge clk) disable iff (rst)
      (pin9Sel == gafs_pkg::FN_4 && gpioOe[1]) |-> pinOut[1] == memoryResetN)
      else $error("memory reset not routed");
   pin8Mr_a: assert property (@(posedge clk) disable iff (rst)
      (pin8Sel == gafs_pkg::FN_1 && !gpioOe[0]) |-> manualResetN == pinIn[0])
      else $error("manual reset wrong");
   unassigned_a: assert property (@(posedge clk) disable iff (rst)
      pin8Sel > gafs_pkg::FN_4 |-> (pinOut[0] == gpioOut[0] && pinOe[0] == gpioOe[0]))
      else $error("unassigned code not gpio");
   // register side checks
   selDUpper_a: assert property (@(posedge clk) disable iff (rst)
      (wr && hitD && !smReset) |=> selD_q[15:gafs_pkg::SEL_W] == '0)
      else $error("select d upper bits kept");
   rdIdle_a: assert property (@(posedge clk) disable iff (rst)
      !rd |=> rdata == 16'h0000)
      else $error("read data not idle");
   smWins_a: assert property (@(posedge clk) disable iff (rst)
      (smReset && wr) |=> (selC_q == gafs_pkg::DEF_SEL_C && selD_q == gafs_pkg::DEF_SEL_D))
      else $error("write beat state machine reset");
   // routing checks per role
   pin12Reset_a: assert property (@(posedge clk) disable iff (rst)
      (pin12Sel == gafs_pkg::FN_1 && !gpioOe[4]) |-> chipReset == pinIn[4])
      else $error("chip reset not routed");
   pin12Clk_a: assert property (@(posedge clk) disable iff (rst)
      (pin12Sel == gafs_pkg::FN_4 && gpioOe[4]) |-> (pinOe[4] && pinOut[4] == clk32k))
      else $error("pin12 clock not routed");
   pin11SinkD_a: assert property (@(posedge clk) disable iff (rst)
      pin11Sel == gafs_pkg::FN_1 |-> (pinOe[3] && pinOut[3] == currentSinkDCtrl))
      else $error("sink d not routed");
   pin10Charge_a: assert property (@(posedge clk) disable iff (rst)
      pin10Sel == gafs_pkg::FN_3 |-> (pinOe[2] && pinOut[2] == chargeIndicator))
      else $error("charge indicator not routed");
   pin10Off_a: assert property (@(posedge clk) disable iff (rst)
      (pin10Sel == gafs_pkg::FN_3 && pinIn[2]) |-> powerOffRequest)
      else $error("pin10 power-off lost");
   pin9Alive_a: assert property (@(posedge clk) disable iff (rst)
      (pin9Sel == gafs_pkg::FN_1 && !gpioOe[1]) |-> hostAlivePulse == pinIn[1])
      else $error("host alive not routed");
   pin9Mask_a: assert property (@(posedge clk) disable iff (rst)
      (pin9Sel == gafs_pkg::FN_2 && !gpioOe[1]) |-> seqMask == pinIn[1])
      else $error("sequencing mask not routed");
   pin9Line_a: assert property (@(posedge clk) disable iff (rst)
      (pin9Sel == gafs_pkg::FN_2 && gpioOe[1]) |-> (pinOe[1] && pinOut[1] == lineAboveBatteryFlag))
      else $error("pin9 line flag not routed");
   pin9Fault_a: assert property (@(posedge clk) disable iff (rst)
      (pin9Sel == gafs_pkg::FN_3 && gpioOe[1]) |-> (pinOe[1] && pinOut[1] == batteryFaultN))
      else $error("battery fault not routed");
   pin8Clk_a: assert property (@(posedge clk) disable iff (rst)
      (pin8Sel == gafs_pkg::FN_2 && !gpioOe[0]) |-> adcBitClockIn == pinIn[0])
      else $error("bit clock input wrong");
   pin8Rst_a: assert property (@(posedge clk) disable iff (rst)
      (pin8Sel == gafs_pkg::FN_4 && gpioOe[0]) |-> (pinOe[0] && pinOut[0] == systemResetN))
      else $error("system reset not routed");
   pin8Hib_a: assert property (@(posedge clk) disable iff (rst)
      (pin8Sel == gafs_pkg::FN_4 && !gpioOe[0]) |-> hibernateEdge == pinIn[0])
      else $error("edge hibernate wrong");
   gpio12_a: assert property (@(posedge clk) disable iff (rst)
      pin12Sel > gafs_pkg::FN_4 |-> (pinOut[4] == gpioOut[4] && pinOe[4] == gpioOe[4]))
      else $error("pin12 unassigned not gpio");
   // scenario coverage
   smCov_c: cover property (@(posedge clk) disable iff (rst) smReset ##1 (wr && hitC));
   wakeCov_c: cover property (@(posedge clk) disable iff (rst) pin11Sel == gafs_pkg::FN_2 && !wakeRequestN);
   clkCov_c: cover property (@(posedge clk) disable iff (rst) pin12Sel == gafs_pkg::FN_4 && pinOe[4]);
endmodule
